/* File: logic/rpm_params.svh */
// constants of the receiver pin-mode control block
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RPM_OFS_CTRL 12'h000
`define RPM_OFS_STATUS 12'h004
`define RPM_OFS_WCOUNT 12'h008
`define RPM_OFS_TRSCOUNT 12'h00c

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RPM_CTRL_RATE_LSB 0
`define RPM_CTRL_RATE_MSB 2
`define RPM_CTRL_RESET 3'h0
`define RPM_ST_WIDTH 0
`define RPM_ST_PROC 1
`define RPM_ST_SDO_EN 2
`define RPM_ST_STANDBY 3
`define RPM_ST_BUF_LSB 4
`define RPM_ST_BUF_MSB 5

// ----------------------------------------
// stream widths and sync marker
// ----------------------------------------
`define RPM_WORD_W 20
`define RPM_HALF_W 10
`define RPM_SYNC_WORD 10'h3ff

// ----------------------------------------
// bit clock phase steps, scaled to the core clock
// (full rate 2.97 Gb/s maps to half the core clock)
// ----------------------------------------
`define RPM_STEP_3G 16'h8000
`define RPM_STEP_3G_M 16'h7fdf
`define RPM_STEP_HD 16'h4000
`define RPM_STEP_HD_M 16'h3ff0
`define RPM_STEP_SD 16'h0ba3

`endif

/* File: logic/rpm_pkg.sv */
// types of the receiver pin-mode control block
`default_nettype none
package rpm_pkg;
  // loop-through line rate selection
  typedef enum logic [2:0] {
    RATE_3G = 3'b000,   // 2.97 Gb/s
    RATE_3G_M = 3'b001, // 2.97/1.001 Gb/s
    RATE_HD = 3'b010,   // 1.485 Gb/s
    RATE_HD_M = 3'b011, // 1.485/1.001 Gb/s
    RATE_SD = 3'b100    // 270 Mb/s
  } rpm_rate_t;

  // parallel output beat phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, // nothing presented
    PH_FULL = 2'b01, // whole 20-bit word presented
    PH_HIGH = 2'b10, // upper half presented (10-bit mode)
    PH_LOW = 2'b11   // lower half presented (10-bit mode)
  } rpm_phase_t;

  typedef logic [19:0] rpm_word_t;
endpackage
`default_nettype wire

/* File: logic/rpm_strm_if.sv */
// valid/ready word stream between the block's own modules
`default_nettype none
interface rpm_strm_if;
  import rpm_pkg::*;
  logic valid;     // word offered
  logic ready;     // word may be taken
  rpm_word_t data; // word itself
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: logic/rpm_buf.sv */
// two-entry buffer so that a stalled receiver loses no word
`include "rpm_params.svh"
`default_nettype none
module rpm_buf
  import rpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  rpm_strm_if.snk up,
  rpm_strm_if.src dn,
  output logic [1:0] level
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0][19:0] mem; // two storage words
    logic wp;              // write slot
    logic rp;              // read slot
    logic [1:0] cnt;       // words held
  } rpm_buf_st_t;

  rpm_buf_st_t s_q, s_d;
  logic push, pop;

  // honest full and empty
  assign up.ready = (s_q.cnt != 2'd2);
  assign dn.valid = (s_q.cnt != 2'd0);
  assign dn.data = s_q.mem[s_q.rp];
  assign level = s_q.cnt;
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // next state
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = up.data;
      s_d.wp = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    // count follows both sides
    case ({push, pop})
      2'b10: s_d.cnt = s_q.cnt + 2'd1;
      2'b01: s_d.cnt = s_q.cnt - 2'd1;
      default: s_d.cnt = s_q.cnt;
    endcase
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* File: logic/rpm_ser.sv */
// loop-through serialiser: shifts 20-bit words out, msb first
`include "rpm_params.svh"
`default_nettype none
module rpm_ser
  import rpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_en,      // one pulse per serial bit
  input wire logic out_en,      // stage enabled
  input wire logic word_valid,  // word offered for loop-through
  input wire rpm_word_t word,   // word to send
  output logic sdo_p,           // true line
  output logic sdo_n            // complement line
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rpm_word_t sh;    // shift register
    logic [4:0] left; // bits still to send
    logic p;          // true line level
    logic n;          // complement line level
  } rpm_ser_st_t;

  rpm_ser_st_t s_q, s_d;

  assign sdo_p = s_q.p;
  assign sdo_n = s_q.n;

  // next state
  always_comb begin
    s_d = s_q;
    if (!out_en) begin
      // parked stage: both lines high, nothing queued
      s_d.p = 1'b1;
      s_d.n = 1'b1;
      s_d.left = 5'd0;
    end else if (bit_en) begin
      if (s_q.left == 5'd0) begin
        // idle line shows zero until a word arrives
        s_d.p = word_valid ? word[19] : 1'b0;
        s_d.n = word_valid ? ~word[19] : 1'b1;
        if (word_valid) begin
          s_d.sh = {word[18:0], 1'b0};
          s_d.left = 5'd19;
        end
      end else begin
        s_d.p = s_q.sh[19];
        s_d.n = ~s_q.sh[19];
        s_d.sh = {s_q.sh[18:0], 1'b0};
        s_d.left = s_q.left - 5'd1;
      end
    end else if (s_q.p && s_q.n) begin
      // leave the parked level at the next edge, so an enabled stage shows both lines high for one cycle at most
      s_d.p = 1'b0;
      s_d.n = 1'b1;
    end
  end

  // registers; lines rest high out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{sh: '0, left: 5'd0, p: 1'b1, n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* File: logic/rpm_ctrl.sv */
// receiver pin-mode control: bus width, processing, loop-through, standby
//
// The address map and register access over APB were decided locally.
`include "rpm_params.svh"
`default_nettype none
module rpm_ctrl
  import rpm_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  // mode pins
  input wire logic BUS_WIDTH_SELECT,
  input wire logic PROCESSING_ENABLE,
  input wire logic LOOP_SERIAL_OUT_ENABLE,
  input wire logic STANDBY,
  // received word stream
  input wire logic [19:0] RX_WORD,
  input wire logic RX_VALID,
  output logic RX_READY,
  // parallel output bus
  output logic [19:0] PDATA,
  output logic PDATA_VALID,
  input wire logic PDATA_READY,
  output logic PDATA_OE,
  // loop-through serial output
  output logic LOOP_SERIAL_OUT_P,
  output logic LOOP_SERIAL_OUT_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rpm_word_t pw;     // processing stage word
    logic pv;          // processing stage valid
    logic [15:0] trs;  // sync markers seen by processing
    rpm_word_t cur;    // word being put on the bus
    rpm_phase_t ph;    // output beat phase
    logic [19:0] pd;   // parallel data register
    logic [31:0] wcnt; // words delivered on the bus
    logic [2:0] rate;  // loop-through rate code
    logic [15:0] acc;  // bit clock phase accumulator
    logic bit_en;      // one pulse per serial bit
    logic [31:0] rd;   // read data register
    logic err;         // unmapped address flag
  } rpm_st_t;

  rpm_st_t s_q, s_d;

  rpm_strm_if to_buf ();   // processing to buffer
  rpm_strm_if from_buf (); // buffer to output formatter

  logic [1:0] buf_level;  // words held in buffer
  logic run;              // not in standby
  logic loop_en;          // serial stage enabled
  logic in_take;          // word accepted from rx
  logic stage_free;       // processing stage can load
  logic beat_done;        // current beat accepted
  logic setup;            // apb setup phase
  logic access;           // apb access phase
  logic [15:0] step;      // phase step for the rate
  logic [16:0] acc_sum;   // accumulator with carry

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign run = !STANDBY;
  assign loop_en = LOOP_SERIAL_OUT_ENABLE && run;

  // ----------------------------------------
  // input and processing stage
  // ----------------------------------------
  // processing stage drains into the buffer when it can
  assign stage_free = !s_q.pv || to_buf.ready;
  // standby refuses words; bypass follows buffer space
  assign RX_READY = run && (PROCESSING_ENABLE ? stage_free : to_buf.ready);
  assign in_take = RX_VALID && RX_READY;

  // bypass skips the stage, active path goes through it
  always_comb begin
    if (PROCESSING_ENABLE) begin
      to_buf.valid = s_q.pv && run;
      to_buf.data = s_q.pw;
    end else begin
      to_buf.valid = RX_VALID && run;
      to_buf.data = RX_WORD;
    end
  end

  // ----------------------------------------
  // two-entry buffer
  // ----------------------------------------
  rpm_buf u_buf (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .up(to_buf.snk),
    .dn(from_buf.src),
    .level(buf_level)
  );

  // ----------------------------------------
  // output formatter
  // ----------------------------------------
  assign beat_done = PDATA_VALID && PDATA_READY;
  // next buffer word taken when idle or once the current word's last beat leaves
  assign from_buf.ready = run && (s_q.ph == PH_IDLE
    || (beat_done && (s_q.ph == PH_FULL || s_q.ph == PH_LOW)));
  assign PDATA = s_q.pd;
  assign PDATA_VALID = (s_q.ph != PH_IDLE) && run;
  assign PDATA_OE = run;

  // ----------------------------------------
  // loop-through bit clock
  // ----------------------------------------
  // phase step per selected rate; unused codes fall to full rate
  always_comb begin
    case (rpm_rate_t'(s_q.rate))
      RATE_3G: step = `RPM_STEP_3G;
      RATE_3G_M: step = `RPM_STEP_3G_M;
      RATE_HD: step = `RPM_STEP_HD;
      RATE_HD_M: step = `RPM_STEP_HD_M;
      RATE_SD: step = `RPM_STEP_SD;
      default: step = `RPM_STEP_3G;
    endcase
  end
  assign acc_sum = {1'b0, s_q.acc} + {1'b0, step};

  // loop-through serialises whichever offered word meets a free bit slot, without stalling the stream
  rpm_ser u_ser (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .bit_en(s_q.bit_en),
    .out_en(loop_en),
    .word_valid(RX_VALID && run),
    .word(RX_WORD),
    .sdo_p(LOOP_SERIAL_OUT_P),
    .sdo_n(LOOP_SERIAL_OUT_N)
  );

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign PREADY = 1'b1;
  assign PRDATA = s_q.rd;
  assign PSLVERR = access && s_q.err;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // processing stage: register and count sync markers
    if (PROCESSING_ENABLE && run) begin
      if (stage_free) begin
        s_d.pv = in_take;
        s_d.pw = RX_WORD;
        if (in_take && RX_WORD[9:0] == `RPM_SYNC_WORD) begin
          s_d.trs = s_q.trs + 16'd1;
        end
      end
    end else begin
      // no processing in bypass or standby
      s_d.pv = 1'b0;
    end
    // output beats; the bus stays static in standby
    if (run) begin
      unique case (s_q.ph)
        PH_IDLE: begin
          s_d.ph = PH_IDLE;
        end
        PH_FULL: begin
          if (beat_done) begin
            s_d.ph = PH_IDLE;
            s_d.wcnt = s_q.wcnt + 32'd1;
          end
        end
        PH_HIGH: begin
          // second beat carries the lower half
          if (beat_done) begin
            s_d.ph = PH_LOW;
            s_d.pd = {10'h000, s_q.cur[9:0]};
          end
        end
        PH_LOW: begin
          if (beat_done) begin
            s_d.ph = PH_IDLE;
            s_d.wcnt = s_q.wcnt + 32'd1;
          end
        end
      endcase
      // load a fresh word when the formatter frees up
      if (from_buf.valid && from_buf.ready) begin
        s_d.cur = from_buf.data;
        if (BUS_WIDTH_SELECT) begin
          s_d.ph = PH_FULL;
          s_d.pd = from_buf.data;
        end else begin
          s_d.ph = PH_HIGH;
          s_d.pd = {10'h000, from_buf.data[19:10]};
        end
      end
    end
    // bit clock enable from the phase accumulator
    s_d.acc = acc_sum[15:0];
    s_d.bit_en = acc_sum[16] && loop_en;
    // register reads latched in setup, writes at the access edge
    if (setup) begin
      s_d.err = 1'b0;
      s_d.rd = 32'h0000_0000;
      case (PADDR)
        `RPM_OFS_CTRL: s_d.rd = {29'h0, s_q.rate};
        `RPM_OFS_STATUS: s_d.rd = {26'h0, buf_level, STANDBY,
          LOOP_SERIAL_OUT_ENABLE, PROCESSING_ENABLE, BUS_WIDTH_SELECT};
        `RPM_OFS_WCOUNT: s_d.rd = s_q.wcnt;
        `RPM_OFS_TRSCOUNT: s_d.rd = {16'h0, s_q.trs};
        default: s_d.err = 1'b1;
      endcase
    end
    if (access && PWRITE && PADDR == `RPM_OFS_CTRL) begin
      s_d.rate = PWDATA[`RPM_CTRL_RATE_MSB:`RPM_CTRL_RATE_LSB];
    end
  end

  // registers
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* File: bench/rpm_ctrl_monitor.sv */
// concurrent checks on the pin-mode control ports
`default_nettype none
module rpm_ctrl_monitor (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic BUS_WIDTH_SELECT,
  input wire logic LOOP_SERIAL_OUT_ENABLE,
  input wire logic STANDBY,
  input wire logic RX_READY,
  input wire logic [19:0] PDATA,
  input wire logic PDATA_VALID,
  input wire logic PDATA_READY,
  input wire logic PDATA_OE,
  input wire logic LOOP_SERIAL_OUT_P,
  input wire logic LOOP_SERIAL_OUT_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------
  // loop-through lines
  // ----------------------------------------
  // two edges of an enabled, awake loop stage
  sequence s_loop_live;
    (LOOP_SERIAL_OUT_ENABLE && !STANDBY) [*2];
  endsequence
  a_loop_off_high: assert property (!LOOP_SERIAL_OUT_ENABLE |=> LOOP_SERIAL_OUT_P && LOOP_SERIAL_OUT_N)
    else $error("loop lines not parked high");
  a_stby_loop_high: assert property (STANDBY |=> LOOP_SERIAL_OUT_P && LOOP_SERIAL_OUT_N)
    else $error("loop lines not high in standby");
  a_loop_live_diff: assert property (s_loop_live |-> LOOP_SERIAL_OUT_P != LOOP_SERIAL_OUT_N)
    else $error("loop lines not complementary");
  // ----------------------------------------
  // standby and parallel bus
  // ----------------------------------------
  a_stby_pins_off: assert property (PDATA_OE == !STANDBY)
    else $error("output enable does not follow standby");
  a_stby_no_flow: assert property (STANDBY |-> !PDATA_VALID && !RX_READY)
    else $error("data moves in standby");
  a_stby_bus_frozen: assert property (STANDBY && $past(STANDBY) |-> $stable(PDATA))
    else $error("parallel bus moves in standby");
  a_narrow_upper_zero: assert property (!BUS_WIDTH_SELECT && PDATA_VALID |-> PDATA[19:10] == 10'h0)
    else $error("upper bits used in narrow mode");
  a_stall_holds_beat: assert property (PDATA_VALID && !PDATA_READY |=> STANDBY || (PDATA_VALID && $stable(PDATA)))
    else $error("stalled beat lost or changed");
endmodule
bind rpm_ctrl rpm_ctrl_monitor rpm_ctrl_monitor_i (.CORE_CLK, .NRST, .BUS_WIDTH_SELECT,
  .LOOP_SERIAL_OUT_ENABLE, .STANDBY, .RX_READY, .PDATA, .PDATA_VALID, .PDATA_READY, .PDATA_OE,
  .LOOP_SERIAL_OUT_P, .LOOP_SERIAL_OUT_N);
`default_nettype wire

/* File: bench/rpm_sink.sv */
// board-side receiver of the parallel bus, with a stall control
`default_nettype none
module rpm_sink (
  input wire logic clk,
  input wire logic stall,
  input wire logic [19:0] data,
  input wire logic valid,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] beats[$]; // every beat taken, in order
  // refuse beats while the board stalls
  assign ready = !stall;
  // take a beat at the edge where both handshake sides are high
  always @(posedge clk) begin
    if (valid === 1'b1 && ready) begin
      beats.push_back(data);
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench of the pin-mode control block
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  import rpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, width_sel = 1, proc_en = 0, loop_en = 1, standby = 0, stall = 0;
  logic [19:0] rx_word = 20'h0;
  logic rx_valid = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic rx_ready, pdata_valid, pdata_ready, pdata_oe, lp_p, lp_n, pready, pslverr, prev;
  logic [19:0] pdata, w = 20'h2468a;
  logic [31:0] prdata;
  int errors = 0, compares = 0, sent = 0, lat_b, lat_p, tg;
  always #5 clk = ~clk;
  // count every word the block takes, at the edge where it is taken
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) sent++;
  end
  rpm_ctrl rpm_ctrl_i (.CORE_CLK(clk), .NRST(nrst), .BUS_WIDTH_SELECT(width_sel),
    .PROCESSING_ENABLE(proc_en), .LOOP_SERIAL_OUT_ENABLE(loop_en), .STANDBY(standby),
    .RX_WORD(rx_word), .RX_VALID(rx_valid), .RX_READY(rx_ready), .PDATA(pdata),
    .PDATA_VALID(pdata_valid), .PDATA_READY(pdata_ready), .PDATA_OE(pdata_oe),
    .LOOP_SERIAL_OUT_P(lp_p), .LOOP_SERIAL_OUT_N(lp_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));
  rpm_sink rpm_sink_i (.clk(clk), .stall(stall), .data(pdata), .valid(pdata_valid),
    .ready(pdata_ready));
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  // offer one word; n counts edges from its take until a beat shows
  task automatic rx(input logic [19:0] x, output int n);
    rx_word <= x; rx_valid <= 1;
    @(posedge clk);
    while (rx_ready !== 1'b1) @(posedge clk);
    rx_valid <= 0;
    n = 0;
    do begin @(posedge clk); n++; end while (pdata_valid !== 1'b1 && n < 20);
  endtask
  task automatic print_verdict;
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    apb(0, 12'h000, 0); `CHK("rate reset", 32'h0, rd)
    apb(0, 12'h004, 0); `CHK("pin status", 32'h5, rd)
    apb(0, 12'h010, 0); `CHK("unmapped err", 1'b1, er)
    rx(20'h12345, lat_b);
    proc_en <= 1;
    rx(20'h553ff, lat_p);
    `CHK("proc latency", lat_b + 1, lat_p)
    apb(0, 12'h00c, 0); `CHK("marker count", 32'h1, rd)
    proc_en <= 0; stall <= 1; rpm_sink_i.beats.delete();
    rx(20'habcde, lat_b);
    rx(20'h13579, lat_b);
    stall <= 0;
    repeat (10) @(posedge clk);
    `CHK("wide beat0", 20'habcde, rpm_sink_i.beats[0])
    `CHK("wide beat1", 20'h13579, rpm_sink_i.beats[1])
    width_sel <= 0; rpm_sink_i.beats.delete();
    rx(w, lat_b);
    repeat (10) @(posedge clk);
    `CHK("narrow hi", {10'h0, w[19:10]}, rpm_sink_i.beats[0])
    `CHK("narrow lo", {10'h0, w[9:0]}, rpm_sink_i.beats[1])
    // every line rate drives the loop output
    for (int r = 0; r < 5; r++) begin
      apb(1, 12'h000, r);
      // keep words coming so that one meets a free bit slot at any rate
      rx_word <= 20'haaaaa;
      rx_valid <= 1;
      tg = 0;
      prev = lp_p;
      repeat (500) begin @(posedge clk); if (lp_p !== prev) tg++; prev = lp_p; end
      rx_valid <= 0;
      repeat (10) @(posedge clk);
      `CHK("loop toggles", 1'b1, tg > 0)
    end
    apb(0, 12'h008, 0); `CHK("word count", sent, rd)
    loop_en <= 0;
    repeat (3) @(posedge clk);
    `CHK("parked lines", 2'b11, {lp_p, lp_n})
    loop_en <= 1; standby <= 1;
    repeat (3) @(posedge clk);
    `CHK("stby lines", 2'b11, {lp_p, lp_n})
    `CHK("stby flow", 2'b00, {rx_ready, pdata_oe})
    standby <= 0;
    repeat (3) @(posedge clk);
    `CHK("wake oe", 1'b1, pdata_oe)
    print_verdict();
  end
  // cut a hang short
  initial begin
    #500000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
